// [hdl/encoder_supervisor_regs.svh]
// register offsets, field positions, reset values and timing counts for the encoder supervisor
`ifndef ENCODER_SUPERVISOR_REGS_SVH
`define ENCODER_SUPERVISOR_REGS_SVH

// register indices (byte address = 4 * index)
`define REG_PULSES_PER_REV 4'h0
`define REG_STOP_SELECT 4'h1
`define REG_PHASE_CTRL 4'h2
`define REG_MONITOR_DIVIDER 4'h3
`define REG_OVERSPEED_LEVEL 4'h4
`define REG_OVERSPEED_DELAY 4'h5
`define REG_DEVIATION_LEVEL 4'h6
`define REG_DEVIATION_DELAY 4'h7
`define REG_GEAR_TEETH 4'h8
`define REG_OPEN_DELAY 4'h9
`define REG_MIN_FREQ 4'ha
`define REG_AGREE_WIDTH 4'hb
`define REG_MAX_FREQ 4'hc
`define REG_STATUS 4'hd
`define REG_SPEED 4'he

// field positions in the stop select register
`define FLD_OPEN_STOP_LSB 0
`define FLD_OVERSPEED_STOP_LSB 2
`define FLD_DEVIATION_STOP_LSB 4

// reset values
`define RST_PULSES_PER_REV 16'd600
`define RST_OPEN_STOP 2'd1
`define RST_OVERSPEED_STOP 2'd1
`define RST_DEVIATION_STOP 2'd3
`define RST_MONITOR_DIVIDER 8'd1
`define RST_OVERSPEED_LEVEL 8'd115
`define RST_OVERSPEED_DELAY 8'd10
`define RST_DEVIATION_LEVEL 8'd10
`define RST_DEVIATION_DELAY 8'd5
`define RST_OPEN_DELAY 8'd20
`define RST_TEETH 10'd0

// setting limits
`define MAX_OVERSPEED_LEVEL 8'd120
`define MAX_OVERSPEED_DELAY 8'd20
`define MAX_DEVIATION_LEVEL 8'd50
`define MAX_FAULT_DELAY 8'd100
`define MAX_TEETH 10'd1000
`define MAX_DIV_M 7'd32

// timing: delays are held in tenths of a second
`define CLK_PERIOD_NS 50
`define TENTH_SECOND_NS 100000000
`define TENTH_CYCLES (`TENTH_SECOND_NS / `CLK_PERIOD_NS)
// speed is sampled over a one second gate
`define GATE_TENTHS 10

`endif

// [hdl/encoder_supervisor_pkg.sv]
// types shared by the encoder supervisor design files
package encoder_supervisor_pkg;

  typedef enum logic [1:0] {
    stop_ramp,
    stop_coast,
    stop_fast,
    stop_continue
  } stop_method_type;

  typedef enum logic [1:0] {
    dir_idle,
    dir_forward,
    dir_reverse
  } direction_type;

endpackage

// [hdl/fault_timer.sv]
// qualification timer: condition must persist past a delay in tenths of a second
`timescale 1ns/1ps
module fault_timer #(
  parameter int TENTH_CYCLES = 2000000
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic condition_i,
  input wire logic [7:0] delay_i,
  input wire logic fault_clear_i,
  output logic fault_o
);
  logic [31:0] cycle_reg;
  logic [31:0] cycle_next;
  logic [7:0] tenth_reg;
  logic [7:0] tenth_next;
  logic fault_reg;
  logic fault_next;
  wire tenth_tick = (cycle_reg == 32'(TENTH_CYCLES - 1));
  wire expired = (tenth_reg >= delay_i);

  // condition lapsing restarts the count from zero
  assign cycle_next = (!condition_i || tenth_tick) ? 32'h0 : cycle_reg + 32'h1;
  assign tenth_next = !condition_i ? 8'h0 :
    (tenth_tick && !expired) ? tenth_reg + 8'h1 : tenth_reg;
  // fault only once the delay has fully passed with the condition held; set beats clear
  assign fault_next = (condition_i && expired && tenth_tick) ? 1'b1 :
    fault_clear_i ? 1'b0 : fault_reg;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cycle_reg <= 32'h0;
      tenth_reg <= 8'h0;
      fault_reg <= 1'b0;
    end else begin
      cycle_reg <= cycle_next;
      tenth_reg <= tenth_next;
      fault_reg <= fault_next;
    end
  end

  assign fault_o = fault_reg;
endmodule

// [hdl/pulse_monitor_divider.sv]
// monitor output divider with ratio (1+n)/m
`timescale 1ns/1ps
`include "encoder_supervisor_regs.svh"
module pulse_monitor_divider (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic pulse_i,
  input wire logic [7:0] divider_i,
  output logic pulse_o
);
  logic [6:0] acc_reg;
  logic [6:0] acc_next;
  logic out_reg;
  logic out_next;
  // n is 1 from 100 upward, else 0; m is the setting less 100*n kept to 7 bits, 0 taken as 1 and above 32 held at 32
  wire [7:0] hundreds = (divider_i >= 8'd100) ? 8'd1 : 8'd0;
  wire [6:0] m_raw = 7'(divider_i - 8'(hundreds * 8'd100));
  wire [6:0] m_val = (m_raw == 7'd0) ? 7'd1 : (m_raw > `MAX_DIV_M) ? `MAX_DIV_M : m_raw;
  wire [6:0] step = 7'(hundreds) + 7'd1;
  // ratio above one is clamped by emitting at most one per input pulse
  wire [6:0] step_c = (step > m_val) ? m_val : step;
  wire [6:0] sum = acc_reg + step_c;
  wire emit = enable_i && pulse_i && (sum >= m_val);

  // fractional accumulator keeps the long-run count at pulses*(1+n)/m while (1+n) is at most m, else at pulses
  assign acc_next = !enable_i ? 7'h0 : !pulse_i ? acc_reg :
    (sum >= m_val) ? 7'(sum - m_val) : sum;
  assign out_next = emit;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      acc_reg <= 7'h0;
      out_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      out_reg <= out_next;
    end
  end

  assign pulse_o = out_reg;
endmodule

// [hdl/encoder_speed_supervisor.sv]
// encoder speed supervisor: speed measurement, fault timers, stop selection, register port
`timescale 1ns/1ps
`include "encoder_supervisor_regs.svh"
module encoder_speed_supervisor
  import encoder_supervisor_pkg::*;
#(
  parameter int TENTH_CYCLES = `TENTH_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  input wire logic two_phase_card_i,
  input wire logic forward_command_i,
  input wire logic running_i,
  input wire logic accelerating_i,
  input wire logic [15:0] speed_reference_i,
  output logic integral_enable_o,
  output logic monitor_pulse_o,
  output logic [15:0] motor_speed_o,
  output logic overspeed_fault_o,
  output logic speed_deviation_fault_o,
  output logic encoder_open_fault_o,
  output logic stop_request_o,
  output logic [1:0] stop_method_o,
  output logic reverse_detected_o
);
  // ----------------------------------------
  // settings
  // ----------------------------------------
  logic [15:0] pulses_per_rev_reg;
  logic [1:0] open_stop_select_reg;
  logic [1:0] overspeed_stop_select_reg;
  logic [1:0] deviation_stop_select_reg;
  logic phase_order_select_reg;
  logic ramp_integral_enable_reg;
  logic [7:0] monitor_divider_reg;
  logic [7:0] overspeed_level_reg;
  logic [7:0] overspeed_delay_reg;
  logic [7:0] deviation_level_reg;
  logic [7:0] deviation_delay_reg;
  logic [9:0] motor_side_teeth_reg;
  logic [9:0] encoder_side_teeth_reg;
  logic [7:0] open_detect_delay_reg;
  logic [15:0] minimum_frequency_reg;
  logic [15:0] speed_agree_width_reg;
  logic [15:0] max_frequency_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  wire wr_pulses = wr_i && (addr_i == `REG_PULSES_PER_REV);
  wire wr_stop = wr_i && (addr_i == `REG_STOP_SELECT);
  wire wr_phase = wr_i && (addr_i == `REG_PHASE_CTRL);
  wire wr_div = wr_i && (addr_i == `REG_MONITOR_DIVIDER);
  wire wr_os_lvl = wr_i && (addr_i == `REG_OVERSPEED_LEVEL);
  wire wr_os_dly = wr_i && (addr_i == `REG_OVERSPEED_DELAY);
  wire wr_dev_lvl = wr_i && (addr_i == `REG_DEVIATION_LEVEL);
  wire wr_dev_dly = wr_i && (addr_i == `REG_DEVIATION_DELAY);
  wire wr_teeth = wr_i && (addr_i == `REG_GEAR_TEETH);
  wire wr_open_dly = wr_i && (addr_i == `REG_OPEN_DELAY);
  wire wr_min = wr_i && (addr_i == `REG_MIN_FREQ);
  wire wr_agree = wr_i && (addr_i == `REG_AGREE_WIDTH);
  wire wr_max = wr_i && (addr_i == `REG_MAX_FREQ);
  wire wr_status = wr_i && (addr_i == `REG_STATUS);

  // out-of-range writes are clamped so a bad setting cannot disable a fault
  wire [7:0] w8 = wdata_i[7:0];
  wire [7:0] os_lvl_w = (w8 > `MAX_OVERSPEED_LEVEL) ? `MAX_OVERSPEED_LEVEL : w8;
  wire [7:0] os_dly_w = (w8 > `MAX_OVERSPEED_DELAY) ? `MAX_OVERSPEED_DELAY : w8;
  wire [7:0] dev_lvl_w = (w8 > `MAX_DEVIATION_LEVEL) ? `MAX_DEVIATION_LEVEL : w8;
  wire [7:0] dev_dly_w = (w8 > `MAX_FAULT_DELAY) ? `MAX_FAULT_DELAY : w8;
  wire [7:0] open_dly_w = (w8 > `MAX_FAULT_DELAY) ? `MAX_FAULT_DELAY : w8;
  wire [9:0] mt_w = (wdata_i[9:0] > `MAX_TEETH) ? `MAX_TEETH : wdata_i[9:0];
  wire [9:0] et_w = (wdata_i[25:16] > `MAX_TEETH) ? `MAX_TEETH : wdata_i[25:16];

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pulses_per_rev_reg <= `RST_PULSES_PER_REV;
      open_stop_select_reg <= `RST_OPEN_STOP;
      overspeed_stop_select_reg <= `RST_OVERSPEED_STOP;
      deviation_stop_select_reg <= `RST_DEVIATION_STOP;
      phase_order_select_reg <= 1'b0;
      ramp_integral_enable_reg <= 1'b0;
      monitor_divider_reg <= `RST_MONITOR_DIVIDER;
      overspeed_level_reg <= `RST_OVERSPEED_LEVEL;
      overspeed_delay_reg <= `RST_OVERSPEED_DELAY;
      deviation_level_reg <= `RST_DEVIATION_LEVEL;
      deviation_delay_reg <= `RST_DEVIATION_DELAY;
      motor_side_teeth_reg <= `RST_TEETH;
      encoder_side_teeth_reg <= `RST_TEETH;
      open_detect_delay_reg <= `RST_OPEN_DELAY;
      minimum_frequency_reg <= 16'h0;
      speed_agree_width_reg <= 16'h0;
      max_frequency_reg <= 16'h0;
    end else begin
      if (wr_pulses) pulses_per_rev_reg <= wdata_i[15:0];
      if (wr_stop) begin
        open_stop_select_reg <= wdata_i[`FLD_OPEN_STOP_LSB +: 2];
        overspeed_stop_select_reg <= wdata_i[`FLD_OVERSPEED_STOP_LSB +: 2];
        deviation_stop_select_reg <= wdata_i[`FLD_DEVIATION_STOP_LSB +: 2];
      end
      if (wr_phase) begin
        phase_order_select_reg <= wdata_i[0];
        ramp_integral_enable_reg <= wdata_i[1];
      end
      if (wr_div) monitor_divider_reg <= w8;
      if (wr_os_lvl) overspeed_level_reg <= os_lvl_w;
      if (wr_os_dly) overspeed_delay_reg <= os_dly_w;
      if (wr_dev_lvl) deviation_level_reg <= dev_lvl_w;
      if (wr_dev_dly) deviation_delay_reg <= dev_dly_w;
      if (wr_teeth) begin
        motor_side_teeth_reg <= mt_w;
        encoder_side_teeth_reg <= et_w;
      end
      if (wr_open_dly) open_detect_delay_reg <= open_dly_w;
      if (wr_min) minimum_frequency_reg <= wdata_i[15:0];
      if (wr_agree) speed_agree_width_reg <= wdata_i[15:0];
      if (wr_max) max_frequency_reg <= wdata_i[15:0];
    end
  end

  // ----------------------------------------
  // encoder edges and direction
  // ----------------------------------------
  logic a_d_reg;
  logic b_d_reg;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      a_d_reg <= 1'b0;
      b_d_reg <= 1'b0;
    end else begin
      a_d_reg <= phase_a_i;
      b_d_reg <= phase_b_i;
    end
  end
  wire a_rise = phase_a_i && !a_d_reg;
  // on an A rising edge, B low means A leads
  wire a_leads = a_rise && !phase_b_i;
  wire b_leads = a_rise && phase_b_i;
  wire fwd_edge = phase_order_select_reg ? b_leads : a_leads;
  // single-phase cards carry no direction: every pulse counts as the commanded way
  wire dir_mismatch = two_phase_card_i && running_i &&
    (forward_command_i ? !fwd_edge : fwd_edge) && a_rise;

  // ----------------------------------------
  // speed measurement over a one second gate
  // ----------------------------------------
  logic [31:0] tick_reg;
  logic [3:0] gate_reg;
  logic [23:0] count_reg;
  logic [23:0] rate_reg;
  logic [15:0] speed_reg;
  logic [15:0] speed_next;
  logic pulse_seen_reg;
  logic reverse_reg;
  wire tenth_tick = (tick_reg == 32'(TENTH_CYCLES - 1));
  wire gate_end = tenth_tick && (gate_reg == 4'(`GATE_TENTHS - 1));

  // gear ratio falls back to one if either tooth count is zero
  wire gear_on = (motor_side_teeth_reg != 10'd0) && (encoder_side_teeth_reg != 10'd0);
  wire [9:0] num_t = gear_on ? encoder_side_teeth_reg : 10'd1;
  wire [9:0] den_t = gear_on ? motor_side_teeth_reg : 10'd1;
  // pulses per second * 60 / ppr * encoder teeth / motor teeth
  wire [47:0] rpm_num = 48'(rate_reg) * 48'd60 * 48'(num_t);
  wire [47:0] rpm_den = 48'(pulses_per_rev_reg) * 48'(den_t);
  wire [47:0] rpm_q = (rpm_den == 48'h0) ? 48'h0 : rpm_num / rpm_den;
  assign speed_next = (rpm_q > 48'h0000_0000_ffff) ? 16'hffff : rpm_q[15:0];

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tick_reg <= 32'h0;
      gate_reg <= 4'h0;
      count_reg <= 24'h0;
      rate_reg <= 24'h0;
      speed_reg <= 16'h0;
      pulse_seen_reg <= 1'b0;
      reverse_reg <= 1'b0;
    end else begin
      tick_reg <= tenth_tick ? 32'h0 : tick_reg + 32'h1;
      if (tenth_tick) gate_reg <= gate_end ? 4'h0 : gate_reg + 4'h1;
      if (gate_end) begin
        rate_reg <= count_reg;
        count_reg <= 24'(a_rise);
      end else if (a_rise) begin
        count_reg <= count_reg + 24'h1;
      end
      speed_reg <= speed_next;
      // presence of feedback within the current tenth
      pulse_seen_reg <= tenth_tick ? a_rise : (pulse_seen_reg || a_rise);
      if (a_rise) reverse_reg <= dir_mismatch;
    end
  end

  // ----------------------------------------
  // fault conditions, scaled against max frequency
  // ----------------------------------------
  wire [23:0] max_f = 24'(max_frequency_reg);
  wire [23:0] os_limit = 24'((max_f * 24'(overspeed_level_reg)) / 24'd100);
  wire [23:0] dev_limit = 24'((max_f * 24'(deviation_level_reg)) / 24'd100);
  wire [23:0] one_pct = 24'(max_f / 24'd100);
  wire [15:0] ref_v = speed_reference_i;
  // signed difference folded to a magnitude
  wire [16:0] diff_s = {1'b0, speed_reg} - {1'b0, ref_v};
  wire [15:0] deviation = diff_s[16] ? 16'(-diff_s) : diff_s[15:0];
  wire overspeed_cond = 24'(speed_reg) > os_limit;
  wire agree_now = running_i && (deviation <= speed_agree_width_reg);
  logic armed_reg;
  wire deviation_cond = armed_reg && running_i && (24'(deviation) > dev_limit);
  wire ref_high = (24'(ref_v) > one_pct) || (ref_v > minimum_frequency_reg);
  // no pulse in a whole tenth while commanded to run
  wire open_cond = running_i && ref_high && !pulse_seen_reg && !a_rise;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= running_i && (armed_reg || agree_now);
    end
  end

  // ----------------------------------------
  // fault timers and stop selection
  // ----------------------------------------
  wire os_fault;
  wire dev_fault;
  wire open_fault;
  wire clear_faults = wr_status && wdata_i[0];

  fault_timer #(.TENTH_CYCLES(TENTH_CYCLES)) u_os_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .condition_i(overspeed_cond),
    .delay_i(overspeed_delay_reg),
    .fault_clear_i(clear_faults),
    .fault_o(os_fault)
  );
  fault_timer #(.TENTH_CYCLES(TENTH_CYCLES)) u_dev_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .condition_i(deviation_cond),
    .delay_i(deviation_delay_reg),
    .fault_clear_i(clear_faults),
    .fault_o(dev_fault)
  );
  fault_timer #(.TENTH_CYCLES(TENTH_CYCLES)) u_open_timer (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .condition_i(open_cond),
    .delay_i(open_detect_delay_reg),
    .fault_clear_i(clear_faults),
    .fault_o(open_fault)
  );

  // coast is the harshest stop and continue the mildest, so the strongest one wins
  function automatic logic [2:0] stop_rank(input logic [1:0] sel);
    unique case (stop_method_type'(sel))
      stop_coast: stop_rank = 3'd3;
      stop_fast: stop_rank = 3'd2;
      stop_ramp: stop_rank = 3'd1;
      stop_continue: stop_rank = 3'd0;
    endcase
  endfunction

  wire [2:0] os_rank = os_fault ? stop_rank(overspeed_stop_select_reg) : 3'd0;
  wire [2:0] dev_rank = dev_fault ? stop_rank(deviation_stop_select_reg) : 3'd0;
  wire [2:0] open_rank = open_fault ? stop_rank(open_stop_select_reg) : 3'd0;
  wire [2:0] r1 = (os_rank > dev_rank) ? os_rank : dev_rank;
  wire [2:0] top_rank = (r1 > open_rank) ? r1 : open_rank;
  wire [1:0] method_sel = (top_rank == 3'd3) ? stop_coast :
    (top_rank == 3'd2) ? stop_fast : (top_rank == 3'd1) ? stop_ramp : stop_continue;

  // integral held only while ramping with the setting off
  assign integral_enable_o = ramp_integral_enable_reg || !accelerating_i;

  pulse_monitor_divider u_monitor (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(two_phase_card_i),
    .pulse_i(a_rise),
    .divider_i(monitor_divider_reg),
    .pulse_o(monitor_pulse_o)
  );

  // ----------------------------------------
  // read port
  // ----------------------------------------
  wire [31:0] status_word = {26'h0, method_sel, reverse_reg, open_fault, dev_fault, os_fault};
  assign rdata_next = !rd_i ? 32'h0 :
    (addr_i == `REG_PULSES_PER_REV) ? {16'h0, pulses_per_rev_reg} :
    (addr_i == `REG_STOP_SELECT) ? {26'h0, deviation_stop_select_reg,
      overspeed_stop_select_reg, open_stop_select_reg} :
    (addr_i == `REG_PHASE_CTRL) ? {30'h0, ramp_integral_enable_reg, phase_order_select_reg} :
    (addr_i == `REG_MONITOR_DIVIDER) ? {24'h0, monitor_divider_reg} :
    (addr_i == `REG_OVERSPEED_LEVEL) ? {24'h0, overspeed_level_reg} :
    (addr_i == `REG_OVERSPEED_DELAY) ? {24'h0, overspeed_delay_reg} :
    (addr_i == `REG_DEVIATION_LEVEL) ? {24'h0, deviation_level_reg} :
    (addr_i == `REG_DEVIATION_DELAY) ? {24'h0, deviation_delay_reg} :
    (addr_i == `REG_GEAR_TEETH) ? {6'h0, encoder_side_teeth_reg, 6'h0, motor_side_teeth_reg} :
    (addr_i == `REG_OPEN_DELAY) ? {24'h0, open_detect_delay_reg} :
    (addr_i == `REG_MIN_FREQ) ? {16'h0, minimum_frequency_reg} :
    (addr_i == `REG_AGREE_WIDTH) ? {16'h0, speed_agree_width_reg} :
    (addr_i == `REG_MAX_FREQ) ? {16'h0, max_frequency_reg} :
    (addr_i == `REG_STATUS) ? status_word :
    (addr_i == `REG_SPEED) ? {16'h0, speed_reg} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign motor_speed_o = speed_reg;
  assign overspeed_fault_o = os_fault;
  assign speed_deviation_fault_o = dev_fault;
  assign encoder_open_fault_o = open_fault;
  assign stop_request_o = (top_rank != 3'd0);
  assign stop_method_o = method_sel;
  assign reverse_detected_o = reverse_reg;
endmodule

// [testbench/encoder_model.sv]
// quadrature encoder model driving the supervisor's phase inputs
`timescale 1ns/1ps
module encoder_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] step_i,
  input wire logic reverse_i,
  output logic phase_a_o,
  output logic phase_b_o
);
  // a stopped shaft holds its last state; step_i is cycles per quarter period
  logic [1:0] state_reg;
  logic [7:0] count_reg;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || step_i == 8'h0) begin
      count_reg <= 8'h0;
    end else if (count_reg + 8'h1 >= step_i) begin
      count_reg <= 8'h0;
      state_reg <= reverse_i ? state_reg - 2'h1 : state_reg + 2'h1;
    end else begin
      count_reg <= count_reg + 8'h1;
    end
    if (!reset_n_i) begin
      state_reg <= 2'h0;
    end
  end
  assign phase_a_o = state_reg[0] ^ state_reg[1];
  assign phase_b_o = state_reg[1];
endmodule

// [testbench/encoder_speed_supervisor_assertions.sv]
// port assertions for the encoder speed supervisor
`timescale 1ns/1ps
`include "encoder_supervisor_regs.svh"
module encoder_speed_supervisor_assertions (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic two_phase_card_i,
  input wire logic running_i,
  input wire logic accelerating_i,
  input wire logic integral_enable_o,
  input wire logic monitor_pulse_o,
  input wire logic [15:0] motor_speed_o,
  input wire logic overspeed_fault_o,
  input wire logic speed_deviation_fault_o,
  input wire logic encoder_open_fault_o,
  input wire logic stop_request_o,
  input wire logic [1:0] stop_method_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // a set in the clearing cycle wins, so only quiet cycles promise a held fault
  wire logic clear_w = wr_i && addr_i == `REG_STATUS && wdata_i[0];
  wire logic any_w = overspeed_fault_o || speed_deviation_fault_o || encoder_open_fault_o;
  sequence card_off_s;
    !two_phase_card_i [*2];
  endsequence
  sequence open_rise_s;
    !encoder_open_fault_o ##1 encoder_open_fault_o;
  endsequence
  rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero");
  integral_flat_a: assert property (!accelerating_i |-> integral_enable_o)
    else $error("integral off at constant speed");
  stop_request_a: assert property (stop_request_o == (any_w && stop_method_o != 2'h3))
    else $error("stop request mismatch");
  no_fault_a: assert property (!any_w |-> stop_method_o == 2'h3)
    else $error("stop method without fault");
  overspeed_hold_a: assert property (overspeed_fault_o && !clear_w |=> overspeed_fault_o)
    else $error("overspeed fault dropped");
  deviation_hold_a: assert property (speed_deviation_fault_o && !clear_w |=> speed_deviation_fault_o)
    else $error("deviation fault dropped");
  card_off_a: assert property (card_off_s |-> !monitor_pulse_o)
    else $error("monitor pulse without card");
  pulse_short_a: assert property (monitor_pulse_o |=> !monitor_pulse_o)
    else $error("monitor pulse too long");
  overspeed_speed_a: assert property ($rose(overspeed_fault_o) |-> motor_speed_o != 16'h0)
    else $error("overspeed at zero speed");
  open_run_a: assert property (open_rise_s |-> $past(running_i))
    else $error("open fault while stopped");
endmodule
bind encoder_speed_supervisor encoder_speed_supervisor_assertions u_checker (.*);

// [testbench/tb.sv]
// self-checking bench for the encoder speed supervisor
`timescale 1ns/1ps
`include "encoder_supervisor_regs.svh"
module tb;
  localparam int T = 8;
  logic clk_i, reset_n_i, wr_i, rd_i, phase_a_i, phase_b_i, two_phase_card_i, erev;
  logic forward_command_i, running_i, accelerating_i, integral_enable_o, monitor_pulse_o;
  logic overspeed_fault_o, speed_deviation_fault_o, encoder_open_fault_o, stop_request_o;
  logic reverse_detected_o;
  logic [1:0] stop_method_o;
  logic [2:0] flt;
  logic [3:0] addr_i;
  logic [7:0] step;
  logic [15:0] speed_reference_i, motor_speed_o;
  logic [31:0] wdata_i, rdata_o, seed, rv;
  int n_fail, checks_done, cnt;
  int dv[5] = '{1, 2, 108, 132, 1};
  assign flt = {encoder_open_fault_o, speed_deviation_fault_o, overspeed_fault_o};
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  encoder_speed_supervisor #(.TENTH_CYCLES(T)) u_encoder_speed_supervisor (.*);
  encoder_model u_encoder_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .step_i(step),
    .reverse_i(erev), .phase_a_o(phase_a_i), .phase_b_o(phase_b_i));
  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // speed and pulse counts depend on gate phase, so one or two counts of slack
  task automatic near(input string what, input int exp, input logic [15:0] got, input int tol);
    checks_done++;
    if ($isunknown(got) || int'(got) > exp + tol || int'(got) + tol < exp) begin
      n_fail++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    check("register", exp, rdata_o);
  endtask
  task automatic wr_chk(input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
    wr_reg(a, d);
    chk_reg(a, exp);
  endtask
  task automatic pause;
    repeat (2 * T) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic wait_flt(input int b, input int lim);
    for (int i = 0; i < lim && flt[b] !== 1'b1; i++) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  function automatic int exp_speed(int p, int ppr, int e, int m);
    return (e == 0 || m == 0) ? p * 60 / ppr : p * 60 * e / (ppr * m);
  endfunction
  function automatic int exp_mon(int d, int p, bit c);
    int m;
    m = (d % 100 == 0) ? 1 : (d % 100 > 32 ? 32 : d % 100);
    return (c == 0) ? 0 : (d / 100 + 1 > m) ? p : p * (d / 100 + 1) / m;
  endfunction
  initial begin
    #(50 * 20000);
    n_fail++;
    summarize();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    seed = 32'hb774a99e;
    {reset_n_i, wr_i, rd_i, two_phase_card_i, forward_command_i, running_i} = '0;
    {accelerating_i, erev, addr_i, step, speed_reference_i, wdata_i} = '0;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    chk_reg(`REG_PULSES_PER_REV, 32'd600);
    chk_reg(`REG_STOP_SELECT, 32'h35);
    chk_reg(`REG_OVERSPEED_LEVEL, 32'd115);
    chk_reg(`REG_OVERSPEED_DELAY, 32'd10);
    chk_reg(`REG_DEVIATION_DELAY, 32'd5);
    chk_reg(`REG_OPEN_DELAY, 32'd20);
    chk_reg(4'hf, 32'h0);
    wr_chk(`REG_OVERSPEED_LEVEL, 32'd200, 32'd120);
    wr_chk(`REG_DEVIATION_LEVEL, 32'd99, 32'd50);
    wr_chk(`REG_GEAR_TEETH, 32'h03ff_03f2, 32'h03e8_03e8);
    rv = 32'($unsigned($random(seed)) % 121);
    wr_chk(`REG_OVERSPEED_LEVEL, rv, rv);
    $display("test registers done");
    wr_reg(`REG_PULSES_PER_REV, 32'd60);
    wr_reg(`REG_MAX_FREQ, 32'd1000);
    wr_reg(`REG_AGREE_WIDTH, 32'd4);
    wr_reg(`REG_OVERSPEED_LEVEL, 32'd115);
    wr_reg(`REG_GEAR_TEETH, 32'h0002_0001);
    {running_i, forward_command_i, two_phase_card_i} <= 3'h7;
    step <= 8'h1;
    speed_reference_i <= 16'd40;
    repeat (25 * T) @(negedge clk_i);
    near("speed", exp_speed(10 * T / 4, 60, 2, 1), motor_speed_o, 2);
    wr_reg(`REG_GEAR_TEETH, 32'h0003_0000);
    speed_reference_i <= 16'd20;
    repeat (25 * T) @(negedge clk_i);
    near("speed", exp_speed(10 * T / 4, 60, 3, 0), motor_speed_o, 1);
    wr_reg(`REG_STOP_SELECT, 32'h09);
    wr_reg(`REG_OVERSPEED_DELAY, 32'd3);
    for (int i = 0; i < 4; i++) begin
      wr_reg(`REG_OVERSPEED_LEVEL, 32'd1);
      repeat (2 * T) @(posedge clk_i);
      wr_reg(`REG_OVERSPEED_LEVEL, 32'd115);
    end
    @(negedge clk_i);
    check("faults", 32'h0, 32'(flt));
    wr_reg(`REG_OVERSPEED_DELAY, 32'd1);
    wr_reg(`REG_OVERSPEED_LEVEL, 32'd1);
    @(negedge clk_i);
    check("faults", 32'h0, 32'(flt));
    wait_flt(0, 6 * T);
    check("faults", 32'h1, 32'(flt));
    check("stop", 32'h6, 32'({stop_request_o, stop_method_o}));
    wr_reg(`REG_OVERSPEED_LEVEL, 32'd115);
    wr_reg(`REG_STATUS, 32'h1);
    @(negedge clk_i);
    check("stop", 32'h3, 32'({overspeed_fault_o, stop_method_o}));
    $display("test overspeed done");
    wr_reg(`REG_DEVIATION_DELAY, 32'd1);
    wr_reg(`REG_DEVIATION_LEVEL, 32'd1);
    speed_reference_i <= 16'd5;
    wait_flt(1, 6 * T);
    check("faults", 32'h2, 32'(flt));
    check("stop", 32'h4, 32'({stop_request_o, stop_method_o}));
    wr_reg(`REG_STOP_SELECT, 32'h39);
    @(negedge clk_i);
    check("stop", 32'h3, 32'({stop_request_o, stop_method_o}));
    wr_reg(`REG_DEVIATION_LEVEL, 32'd50);
    {running_i, step, speed_reference_i} <= {1'b0, 8'h0, 16'd20};
    wr_reg(`REG_OPEN_DELAY, 32'd1);
    wr_reg(`REG_STATUS, 32'h1);
    wait_flt(2, 6 * T);
    check("faults", 32'h0, 32'(flt));
    @(posedge clk_i);
    running_i <= 1'b1;
    wait_flt(2, 8 * T);
    check("faults", 32'h4, 32'(flt));
    check("stop", 32'h5, 32'({stop_request_o, stop_method_o}));
    $display("test open circuit done");
    @(posedge clk_i);
    step <= 8'h1;
    pause();
    check("reverse", 32'h0, 32'(reverse_detected_o));
    @(posedge clk_i);
    erev <= 1'b1;
    pause();
    check("reverse", 32'h1, 32'(reverse_detected_o));
    wr_reg(`REG_PHASE_CTRL, 32'h1);
    pause();
    check("reverse", 32'h0, 32'(reverse_detected_o));
    @(posedge clk_i);
    accelerating_i <= 1'b1;
    pause();
    check("integral", 32'h0, 32'(integral_enable_o));
    wr_reg(`REG_PHASE_CTRL, 32'h3);
    pause();
    check("integral", 32'h1, 32'(integral_enable_o));
    for (int k = 0; k < 5; k++) begin
      wr_reg(`REG_MONITOR_DIVIDER, 32'(dv[k]));
      two_phase_card_i <= (k < 4);
      pause();
      cnt = 0;
      repeat (160) @(negedge clk_i) if (monitor_pulse_o === 1'b1) cnt++;
      near("monitor", exp_mon(dv[k], 40, k < 4), 16'(cnt), 1);
    end
    $display("test direction, integral and monitor done");
    summarize();
  end
endmodule
